/* File: core/temp_alert_pkg.sv */
// Behaviour
// - Compare readings with limits after each conversion
// - Out-of-limit reading sets its status flag
// - Unmasked flags except busy/fault pull event low
// - Event asserts only while mask bit clear
// - Remote high/critical compare signed or unsigned
// - Remote compare span +255.875 to -128
// - Comparator mode releases event when condition clears
// - Comparator mode only when bit set; default off
// - Interrupt mode when bit low; default
// - Interrupt-mode status read with flags sets mask bit
// - Flags clear on read; re-set next conversion
// - Interrupt read clears flags, releases, masks
// - Critical out while remote above critical limit
// - Critical hysteresis from its own register
// - Standby stops continuous conversions
// - Standby PWM keeps running or stops per bit
// - Remote reading 11 bits left justified in 16
// - Local reading and limits are 8 bits
// - Filter widens remote reading to 13 bits
// - Signed offset added to remote reading
// - Event and critical outputs active-low open-drain
// - Alert response address send releases and masks
// - Answer alert response only if event config low
package temp_alert_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_LOCAL_READING = 8'h00;
    localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] ADDR_REMOTE_HIGH_HI = 8'h07;
    localparam logic [7:0] ADDR_REMOTE_LOW_HI = 8'h08;
    localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
    localparam logic [7:0] ADDR_OFFSET_HI = 8'h11;
    localparam logic [7:0] ADDR_OFFSET_LO = 8'h12;
    localparam logic [7:0] ADDR_REMOTE_HIGH_LO = 8'h13;
    localparam logic [7:0] ADDR_REMOTE_LOW_LO = 8'h14;
    localparam logic [7:0] ADDR_CRIT_LIMIT = 8'h19;
    localparam logic [7:0] ADDR_FILTER_MODE = 8'h1a;
    localparam logic [7:0] ADDR_CRIT_HYST = 8'h21;
    localparam logic [7:0] ADDR_ENH_CONFIG = 8'h45;

    // ==========================================================
    // Status bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_LOCAL_HIGH = 6;
    localparam int ST_REMOTE_HIGH = 4;
    localparam int ST_REMOTE_LOW = 3;
    localparam int ST_REMOTE_FAULT = 2;
    localparam int ST_REMOTE_CRIT = 1;
    localparam logic [7:0] ST_EVENT_MASK = 8'h7b;

    // Configuration bit positions
    localparam int CFG_EVENT_MASK = 7;
    localparam int CFG_STANDBY = 6;
    localparam int CFG_PWM_OFF_STBY = 5;
    localparam int CFG_CRIT_OVERRIDE = 1;
    localparam int FM_EVENT_CONFIG = 7;
    localparam int FM_FILTER_EN = 1;
    localparam int FM_COMPARATOR = 0;
    localparam int ENH_UNSIGNED = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] FILTER_MODE_RESET = 8'h00;
    localparam logic [7:0] ENH_RESET = 8'h00;
    localparam logic [7:0] LOCAL_HIGH_RESET = 8'h46;
    localparam logic [15:0] REMOTE_HIGH_RESET = 16'h4600;
    localparam logic [15:0] REMOTE_LOW_RESET = 16'h0000;
    localparam logic [7:0] CRIT_LIMIT_RESET = 8'h55;
    localparam logic [7:0] CRIT_HYST_RESET = 8'h0a;

    // Reading widths
    localparam logic [15:0] MASK_11BIT = 16'hffe0;
    localparam logic [15:0] MASK_13BIT = 16'hfff8;

    // Conversion result from the converter, one pulse per result
    typedef struct packed {
        logic done;
        logic [7:0] local_value;
        logic [15:0] remote_raw;
    } conv_result_t;

    // Register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* File: core/temp_limit_alert_logic.sv */
`timescale 1ns/1ps
module temp_limit_alert_logic
(
    input wire logic ref_clk,
    input wire logic srst,
    input temp_alert_pkg::reg_req_t req,
    output logic [7:0] rdata,
    input temp_alert_pkg::conv_result_t conv,
    input wire logic conv_busy,
    input wire logic remote_fault,
    input wire logic ara_addr_sent,
    output logic ara_enable,
    output logic conv_run,
    output logic pwm_run,
    output logic event_o,
    output logic event_oe_n,
    output logic crit_o,
    output logic crit_oe_n
);

    // ==========================================================
    // Registers
    logic [7:0] config_reg; // Mask, standby, pwm, override
    logic [7:0] filter_mode_reg; // Event config, filter, comparator
    logic [7:0] enh_reg; // Unsigned format select
    logic [7:0] local_high_reg; // Local limit, 8 bits
    logic [15:0] remote_high_reg; // Remote high limit
    logic [15:0] remote_low_reg; // Remote low limit
    logic [7:0] crit_limit_reg; // Remote critical limit, whole degrees
    logic [7:0] crit_hyst_reg; // Critical hysteresis, own register
    logic [15:0] offset_reg; // Signed remote correction
    logic [7:0] local_reading_reg; // Latest local reading
    logic [15:0] remote_reading_reg; // Corrected remote reading
    logic [7:0] status_reg; // Sticky flags
    logic crit_active_reg; // Critical condition with hysteresis
    logic [7:0] live_reg; // Conditions of latest conversion
    logic [7:0] rdata_reg; // Read data, one cycle after strobe
    logic status_read; // Status read this cycle
    logic [7:0] new_flags; // Flags found at conversion end
    logic [16:0] corrected; // Raw plus offset, one bit wider
    logic [15:0] remote_next; // Clamped, masked reading
    logic unsigned_fmt; // Unsigned remote format
    logic signed [9:0] rem_ext; // Remote reading over 10-bit span
    logic signed [9:0] high_ext;
    logic signed [9:0] crit_ext;
    logic signed [9:0] hyst_ext;
    logic any_event; // Any reportable flag

    assign unsigned_fmt = enh_reg[temp_alert_pkg::ENH_UNSIGNED];
    assign status_read = req.rd && (req.addr == temp_alert_pkg::ADDR_STATUS);

    // ==========================================================
    // Offset correction and clamping
    always_comb
    begin
        // Sign-extend offset and zero-extend reading in both formats
        corrected = {1'b0, conv.remote_raw} + {offset_reg[15], offset_reg};
        remote_next = corrected[15:0];
        if (unsigned_fmt)
        begin
            // Clamp rather than roll over; bit 16 flags leaving the range
            if (corrected[16])
                remote_next = offset_reg[15] ? 16'h0000 : 16'hffff;
        end
        else
        begin
            if ((conv.remote_raw[15] == offset_reg[15]) && (corrected[15] != offset_reg[15]))
                remote_next = offset_reg[15] ? 16'h8000 : 16'h7fff;
        end
        // 11 bits normally, 13 with the filter
        if (filter_mode_reg[temp_alert_pkg::FM_FILTER_EN])
            remote_next = remote_next & temp_alert_pkg::MASK_13BIT;
        else
            remote_next = remote_next & temp_alert_pkg::MASK_11BIT;
    end

    // ==========================================================
    // Limit comparisons; remote high and critical on a common signed 10-bit degree span, local and remote low direct
    // Whole degrees, fraction breaks remote high ties; format sets extension so -128 to +255 fits
    always_comb
    begin
        rem_ext = $signed({{2{!unsigned_fmt && remote_next[15]}}, remote_next[15:8]});
        high_ext = $signed({{2{!unsigned_fmt && remote_high_reg[15]}}, remote_high_reg[15:8]});
        crit_ext = $signed({{2{!unsigned_fmt && crit_limit_reg[7]}}, crit_limit_reg});
        hyst_ext = $signed({2'b00, crit_hyst_reg});
        new_flags = 8'h00;
        // Fractional part decides high when whole degrees tie
        new_flags[temp_alert_pkg::ST_LOCAL_HIGH] = conv.local_value > local_high_reg;
        new_flags[temp_alert_pkg::ST_REMOTE_HIGH] = (rem_ext > high_ext)
            || ((rem_ext == high_ext) && (remote_next[7:0] > remote_high_reg[7:0]));
        new_flags[temp_alert_pkg::ST_REMOTE_LOW] = unsigned_fmt ? (remote_next < remote_low_reg)
            : ($signed(remote_next) < $signed(remote_low_reg));
        // Critical holds until reading falls to limit minus hysteresis
        if (crit_active_reg)
            new_flags[temp_alert_pkg::ST_REMOTE_CRIT] = rem_ext > (crit_ext - hyst_ext);
        else
            new_flags[temp_alert_pkg::ST_REMOTE_CRIT] = rem_ext > crit_ext;
        new_flags[temp_alert_pkg::ST_REMOTE_FAULT] = remote_fault;
    end

    // ==========================================================
    // Reading registers and live conditions
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            local_reading_reg <= 8'h00;
            remote_reading_reg <= 16'h0000;
            live_reg <= 8'h00;
            crit_active_reg <= 1'b0;
        end
        else if (conv.done)
        begin
            local_reading_reg <= conv.local_value;
            remote_reading_reg <= remote_next;
            live_reg <= new_flags;
            crit_active_reg <= new_flags[temp_alert_pkg::ST_REMOTE_CRIT];
        end
    end

    // ==========================================================
    // Status flags: set by conversion, cleared by status read; busy bit follows conv_busy
    // Set wins over the read clear so no event is lost
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            status_reg <= 8'h00;
        else
        begin
            for (int i = 0; i < 7; i++)
            begin
                if (conv.done && new_flags[i])
                    status_reg[i] <= 1'b1;
                else if (status_read)
                    status_reg[i] <= 1'b0;
            end
            status_reg[temp_alert_pkg::ST_BUSY] <= conv_busy;
        end
    end

    assign any_event = |(status_reg & temp_alert_pkg::ST_EVENT_MASK);

    // ==========================================================
    // Configuration registers and mask updates
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            config_reg <= temp_alert_pkg::CONFIG_RESET;
            filter_mode_reg <= temp_alert_pkg::FILTER_MODE_RESET;
            enh_reg <= temp_alert_pkg::ENH_RESET;
            local_high_reg <= temp_alert_pkg::LOCAL_HIGH_RESET;
            remote_high_reg <= temp_alert_pkg::REMOTE_HIGH_RESET;
            remote_low_reg <= temp_alert_pkg::REMOTE_LOW_RESET;
            crit_limit_reg <= temp_alert_pkg::CRIT_LIMIT_RESET;
            crit_hyst_reg <= temp_alert_pkg::CRIT_HYST_RESET;
            offset_reg <= 16'h0000;
        end
        else
        begin
            if (req.wr)
            begin
                // Address decode for writes
                if (req.addr == temp_alert_pkg::ADDR_CONFIG)
                    config_reg <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_FILTER_MODE)
                    filter_mode_reg <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_ENH_CONFIG)
                    enh_reg <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_LOCAL_HIGH)
                    local_high_reg <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_REMOTE_HIGH_HI)
                    remote_high_reg[15:8] <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_REMOTE_HIGH_LO)
                    remote_high_reg[7:0] <= req.wdata & 8'he0;
                else if (req.addr == temp_alert_pkg::ADDR_REMOTE_LOW_HI)
                    remote_low_reg[15:8] <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_REMOTE_LOW_LO)
                    remote_low_reg[7:0] <= req.wdata & 8'he0;
                else if (req.addr == temp_alert_pkg::ADDR_CRIT_LIMIT)
                begin
                    // Critical limit locked until override is set
                    if (config_reg[temp_alert_pkg::CFG_CRIT_OVERRIDE])
                        crit_limit_reg <= req.wdata;
                end
                else if (req.addr == temp_alert_pkg::ADDR_CRIT_HYST)
                    crit_hyst_reg <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_OFFSET_HI)
                    offset_reg[15:8] <= req.wdata;
                else if (req.addr == temp_alert_pkg::ADDR_OFFSET_LO)
                    offset_reg[7:0] <= req.wdata & 8'he0;
            end
            // Hardware mask set beats a same-cycle software write
            if (status_read && !filter_mode_reg[temp_alert_pkg::FM_COMPARATOR] && any_event)
                config_reg[temp_alert_pkg::CFG_EVENT_MASK] <= 1'b1;
            if (ara_addr_sent && ara_enable)
                config_reg[temp_alert_pkg::CFG_EVENT_MASK] <= 1'b1;
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rdata_reg <= 8'h00;
        else if (req.rd)
        begin
            if (req.addr == temp_alert_pkg::ADDR_LOCAL_READING)
                rdata_reg <= local_reading_reg;
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_HI)
                rdata_reg <= remote_reading_reg[15:8];
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_LO)
                rdata_reg <= remote_reading_reg[7:0];
            else if (req.addr == temp_alert_pkg::ADDR_STATUS)
                rdata_reg <= status_reg;
            else if (req.addr == temp_alert_pkg::ADDR_CONFIG)
                rdata_reg <= config_reg;
            else if (req.addr == temp_alert_pkg::ADDR_FILTER_MODE)
                rdata_reg <= filter_mode_reg;
            else if (req.addr == temp_alert_pkg::ADDR_ENH_CONFIG)
                rdata_reg <= enh_reg;
            else if (req.addr == temp_alert_pkg::ADDR_LOCAL_HIGH)
                rdata_reg <= local_high_reg;
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_HIGH_HI)
                rdata_reg <= remote_high_reg[15:8];
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_HIGH_LO)
                rdata_reg <= remote_high_reg[7:0];
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_LOW_HI)
                rdata_reg <= remote_low_reg[15:8];
            else if (req.addr == temp_alert_pkg::ADDR_REMOTE_LOW_LO)
                rdata_reg <= remote_low_reg[7:0];
            else if (req.addr == temp_alert_pkg::ADDR_CRIT_LIMIT)
                rdata_reg <= crit_limit_reg;
            else if (req.addr == temp_alert_pkg::ADDR_CRIT_HYST)
                rdata_reg <= crit_hyst_reg;
            else if (req.addr == temp_alert_pkg::ADDR_OFFSET_HI)
                rdata_reg <= offset_reg[15:8];
            else if (req.addr == temp_alert_pkg::ADDR_OFFSET_LO)
                rdata_reg <= offset_reg[7:0];
            else
                rdata_reg <= 8'h00;
        end
    end

    assign rdata = rdata_reg;

    // ==========================================================
    // Output pins, open drain: low enable means pulling low
    // Comparator mode follows live conditions, interrupt mode sticky flags
    always_comb
    begin
        event_o = 1'b0;
        crit_o = 1'b0;
        if (config_reg[temp_alert_pkg::CFG_EVENT_MASK])
            event_oe_n = 1'b1;
        else if (filter_mode_reg[temp_alert_pkg::FM_COMPARATOR])
            event_oe_n = !(|(live_reg & temp_alert_pkg::ST_EVENT_MASK));
        else
            event_oe_n = !any_event;
        crit_oe_n = !crit_active_reg;
    end

    // Alert response only while event config bit is clear and event is pulled
    assign ara_enable = !filter_mode_reg[temp_alert_pkg::FM_EVENT_CONFIG] && !event_oe_n;
    assign conv_run = !config_reg[temp_alert_pkg::CFG_STANDBY];
    assign pwm_run = conv_run || !config_reg[temp_alert_pkg::CFG_PWM_OFF_STBY];

endmodule // temp_limit_alert_logic

/* File: verif/temp_limit_alert_logic_monitor.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker for the limit and event logic
module temp_limit_alert_logic_monitor
(
    input wire logic ref_clk,
    input wire logic srst,
    input temp_alert_pkg::reg_req_t req,
    input temp_alert_pkg::conv_result_t conv,
    input wire logic ara_addr_sent,
    input wire logic ara_enable,
    input wire logic conv_run,
    input wire logic pwm_run,
    input wire logic event_o,
    input wire logic event_oe_n,
    input wire logic crit_o,
    input wire logic crit_oe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // Shadows of config and mode bytes, rebuilt from bus traffic, the event pin and address sent
    logic [7:0] cfg_reg;
    logic [7:0] fm_reg;
    wire logic rd_st = req.rd && req.addr == temp_alert_pkg::ADDR_STATUS;
    // ==========================================================
    // Shadow update: a pulled line at a status read means a flag was set
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_reg <= 8'h00;
            fm_reg <= 8'h00;
        end
        else
        begin
            if (req.wr && req.addr == temp_alert_pkg::ADDR_CONFIG)
                cfg_reg <= req.wdata;
            else if ((rd_st && !fm_reg[0] && !event_oe_n) || ara_addr_sent)
                cfg_reg[7] <= 1'b1;
            if (req.wr && req.addr == temp_alert_pkg::ADDR_FILTER_MODE)
                fm_reg <= req.wdata;
        end
    end
    // ==========================================================
    // Properties
    property p_pins_low; event_o == 1'b0 && crit_o == 1'b0; endproperty
    a_pins_low: assert property (p_pins_low) else $error("open-drain data not low");
    property p_mask_quiet; cfg_reg[7] |-> event_oe_n; endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("event pulled while masked");
    property p_read_release; rd_st && !fm_reg[0] && !conv.done |=> event_oe_n; endproperty
    a_read_release: assert property (p_read_release) else $error("event held after status read");
    property p_ara_release; ara_addr_sent |=> event_oe_n [*2]; endproperty
    a_ara_release: assert property (p_ara_release) else $error("event held after address sent");
    property p_ara_gate; ara_enable |-> !fm_reg[temp_alert_pkg::FM_EVENT_CONFIG] && !event_oe_n; endproperty
    a_ara_gate: assert property (p_ara_gate) else $error("alert answer enabled wrongly");
    property p_standby; conv_run == !cfg_reg[6]; endproperty
    a_standby: assert property (p_standby) else $error("conversion run level wrong");
    property p_pwm; pwm_run == !(cfg_reg[6] && cfg_reg[5]); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm run level wrong");
    property p_event_cause; $fell(event_oe_n) |-> $past(conv.done) || $past(req.wr); endproperty
    a_event_cause: assert property (p_event_cause) else $error("event fell without cause");
    property p_crit_cause; $fell(crit_oe_n) |-> $past(conv.done); endproperty
    a_crit_cause: assert property (p_crit_cause) else $error("critical fell without cause");
    // Main scenarios seen
    c_read_pulled: cover property (rd_st && !event_oe_n);
    c_ara: cover property (ara_addr_sent);
    c_crit_off: cover property ($rose(crit_oe_n));
endmodule // temp_limit_alert_logic_monitor

/* File: verif/alert_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Management host: register master plus event service routine
module alert_host_model
(
    input wire logic ref_clk,
    input wire logic event_n,
    input wire logic [7:0] rdata,
    output temp_alert_pkg::reg_req_t req
);
    initial req = '0;
    // One write cycle; released lines flip so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(negedge ref_clk);
    endtask
    // One read cycle; data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(negedge ref_clk);
        d = rdata;
    endtask
    // Service: wait for the line (bounded), dawdle, read the cause
    task automatic service(input int lag, output logic [7:0] st, output logic seen);
        int n = 0;
        while (event_n !== 1'b0 && n < 64)
        begin
            @(posedge ref_clk);
            n++;
        end
        seen = (event_n === 1'b0);
        repeat (lag) @(posedge ref_clk);
        // Timeout: st stays unknown, failing the caller's check
        if (seen)
            rd(temp_alert_pkg::ADDR_STATUS, st);
    endtask
    // Re-arm at the end of service
    task automatic rearm(input logic [7:0] cfg);
        wr(temp_alert_pkg::ADDR_CONFIG, cfg & 8'h7f);
    endtask
endmodule // alert_host_model

/* File: verif/temp_limit_alert_logic_tb.sv */
`timescale 1ns/1ps
module temp_limit_alert_logic_tb;
    logic ref_clk, srst, conv_busy, remote_fault, ara_addr_sent;
    temp_alert_pkg::conv_result_t conv;
    temp_alert_pkg::reg_req_t req;
    logic [7:0] rdata, st;
    logic ara_enable, conv_run, pwm_run, event_o, event_oe_n, crit_o, crit_oe_n, seen;
    int n_errors = 0, num_checks = 0, cycles = 0;
    // Pulled-up event line seen by the host
    wire logic event_n = event_oe_n ? 1'b1 : event_o;
    temp_limit_alert_logic i_dut (.ref_clk(ref_clk), .srst(srst), .req(req), .rdata(rdata), .conv(conv),
        .conv_busy(conv_busy), .remote_fault(remote_fault), .ara_addr_sent(ara_addr_sent),
        .ara_enable(ara_enable), .conv_run(conv_run), .pwm_run(pwm_run), .event_o(event_o),
        .event_oe_n(event_oe_n), .crit_o(crit_o), .crit_oe_n(crit_oe_n));
    alert_host_model i_host (.ref_clk(ref_clk), .event_n(event_n), .rdata(rdata), .req(req));
    // ==========================================================
    // Clock, timeout and shared checks
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pins(input logic ev, input logic cr);
        check({6'h00, event_oe_n, crit_oe_n}, {6'h00, ev, cr});
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host.rd(a, v);
        check(v, exp);
    endtask
    // One conversion result pulse; stale fields flip afterwards
    task automatic convert(input logic [7:0] l, input logic [15:0] r);
        @(posedge ref_clk);
        conv <= '{done: 1'b1, local_value: l, remote_raw: r};
        @(posedge ref_clk);
        conv <= '{done: 1'b0, local_value: ~l, remote_raw: ~r};
        @(negedge ref_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_reg(temp_alert_pkg::ADDR_CONFIG, 8'h00);
        chk_reg(temp_alert_pkg::ADDR_FILTER_MODE, 8'h00);
        chk_reg(temp_alert_pkg::ADDR_LOCAL_HIGH, temp_alert_pkg::LOCAL_HIGH_RESET);
        chk_reg(8'h04, 8'h00);
        pins(1'b1, 1'b1);
    endtask
    task automatic t_interrupt();
        convert(8'h50, 16'h0000);
        pins(1'b0, 1'b1);
        i_host.service(0, st, seen);
        check(st, 8'h40);
        pins(1'b1, 1'b1);
        chk_reg(temp_alert_pkg::ADDR_CONFIG, 8'h80);
        chk_reg(temp_alert_pkg::ADDR_STATUS, 8'h00);
        i_host.rearm(8'h00);
        convert(8'h46, 16'h0000);
        pins(1'b1, 1'b1);
        convert(8'h47, 16'h0000);
        i_host.service(5, st, seen);
        check({7'h00, seen}, 8'h01);
        check(st, 8'h40);
        i_host.rearm(8'h00);
    endtask
    task automatic t_busy_fault();
        @(posedge ref_clk);
        {conv_busy, remote_fault} <= {2{conv_run}};
        convert(8'h20, 16'h1000);
        pins(1'b1, 1'b1);
        chk_reg(temp_alert_pkg::ADDR_STATUS, 8'h84);
        chk_reg(temp_alert_pkg::ADDR_CONFIG, 8'h00);
        @(posedge ref_clk);
        {conv_busy, remote_fault} <= 2'h0;
    endtask
    task automatic t_remote();
        i_host.wr(temp_alert_pkg::ADDR_REMOTE_LOW_HI, 8'h19);
        convert(8'h20, 16'h18e0);
        pins(1'b0, 1'b1);
        chk_reg(temp_alert_pkg::ADDR_STATUS, 8'h08);
        i_host.rearm(8'h00);
        convert(8'h20, 16'h5600);
        pins(1'b0, 1'b0);
        convert(8'h20, 16'h4c00);
        pins(1'b0, 1'b0);
        convert(8'h20, 16'h4b00);
        pins(1'b0, 1'b1);
        i_host.service(0, st, seen);
        check(st, 8'h12);
        i_host.rearm(8'h00);
    endtask
    task automatic t_format();
        convert(8'h20, 16'hc900);
        i_host.service(0, st, seen);
        check(st & 8'h12, 8'h00);
        i_host.rearm(8'h00);
        i_host.wr(temp_alert_pkg::ADDR_ENH_CONFIG, 8'h08);
        convert(8'h20, 16'hc900);
        pins(1'b0, 1'b0);
        i_host.service(2, st, seen);
        check(st & 8'h12, 8'h12);
        i_host.rearm(8'h00);
        i_host.wr(temp_alert_pkg::ADDR_ENH_CONFIG, 8'h00);
        convert(8'h20, 16'h1900);
        pins(1'b1, 1'b1);
    endtask
    task automatic t_offset();
        i_host.wr(temp_alert_pkg::ADDR_OFFSET_HI, 8'h02);
        convert(8'h20, 16'h45ff);
        chk_reg(temp_alert_pkg::ADDR_REMOTE_HI, 8'h47);
        chk_reg(temp_alert_pkg::ADDR_REMOTE_LO, 8'he0);
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h02);
        convert(8'h20, 16'h45ff);
        chk_reg(temp_alert_pkg::ADDR_REMOTE_LO, 8'hf8);
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h00);
        i_host.service(0, st, seen);
        check(st & 8'h10, 8'h10);
        i_host.rearm(8'h00);
        i_host.wr(temp_alert_pkg::ADDR_OFFSET_HI, 8'h00);
    endtask
    task automatic t_comparator();
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h01);
        convert(8'h50, 16'h1900);
        pins(1'b0, 1'b1);
        convert(8'h30, 16'h1900);
        pins(1'b1, 1'b1);
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h00);
        i_host.service(0, st, seen);
        check(st, 8'h40);
        i_host.rearm(8'h00);
    endtask
    task automatic t_mask_ara();
        i_host.wr(temp_alert_pkg::ADDR_CONFIG, 8'h80);
        convert(8'h50, 16'h1900);
        pins(1'b1, 1'b1);
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h80);
        i_host.rearm(8'h00);
        pins(1'b0, 1'b1);
        check({7'h00, ara_enable}, 8'h00);
        i_host.wr(temp_alert_pkg::ADDR_FILTER_MODE, 8'h00);
        check({7'h00, ara_enable}, 8'h01);
        @(posedge ref_clk);
        ara_addr_sent <= ara_enable;
        @(posedge ref_clk);
        ara_addr_sent <= 1'b0;
        @(negedge ref_clk);
        pins(1'b1, 1'b1);
        chk_reg(temp_alert_pkg::ADDR_CONFIG, 8'h80);
        chk_reg(temp_alert_pkg::ADDR_STATUS, 8'h40);
        i_host.rearm(8'h00);
    endtask
    task automatic t_standby();
        i_host.wr(temp_alert_pkg::ADDR_CONFIG, 8'h40);
        check({6'h00, conv_run, pwm_run}, 8'h01);
        i_host.wr(temp_alert_pkg::ADDR_CONFIG, 8'h60);
        check({6'h00, conv_run, pwm_run}, 8'h00);
        i_host.wr(temp_alert_pkg::ADDR_CONFIG, 8'h00);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        srst = 1'b1;
        {conv, conv_busy, remote_fault, ara_addr_sent} = '0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        t_reset();
        t_interrupt();
        t_busy_fault();
        t_remote();
        t_format();
        t_offset();
        t_comparator();
        t_mask_ara();
        t_standby();
        final_report();
    end
endmodule // temp_limit_alert_logic_tb
bind temp_limit_alert_logic temp_limit_alert_logic_monitor i_mon (.ref_clk(ref_clk), .srst(srst), .req(req),
    .conv(conv), .ara_addr_sent(ara_addr_sent), .ara_enable(ara_enable), .conv_run(conv_run), .pwm_run(pwm_run),
    .event_o(event_o), .event_oe_n(event_oe_n), .crit_o(crit_o), .crit_oe_n(crit_oe_n));
